//--- rtl/ucds_consts.vh
// Contract
// - Set command init-byte error on stop error, bad frame type or reserved type bit.
// - After init or byte error, ignore all following bytes until a link clear.
// - Ignored frames get no error checks and are counted neither valid nor discarded.
// - Set tx-off error when transmitter disabled and host asks for read data.
// - Set command start error when clear arrives before command frame finishes.
// - Set command byte error for any non-init byte error in a command frame.
// - Command CRC mismatch sets command CRC flag and counts frame discarded.
// - Set transmit start error when clear arrives while still sending.
// - Set transmit wait error when turn wait aborted by clear or new command.
// - Set response start error on clear during response frame reception.
// - Response non-init byte error sets flag; remaining bytes are ignored.
// - Response CRC mismatch sets response CRC flag and counts frame discarded.
// - Keep 8-bit discard counter of received and transmitted frames.
// - Reading discard register snapshots discard and valid counts, resets counters.
// - Keep 16-bit valid-frame counter, readable as high and low bytes.
// - Valid counter saturates at all ones, never wraps.
// - Record last OTP block address with corrected single-bit error.
// - Record last OTP block address with detected double-bit error.
`ifndef UCDS_CONSTS_VH
`define UCDS_CONSTS_VH
`define UCDS_IDX_CMD_ERR 12'h781
`define UCDS_IDX_RESP_ERR 12'h782
`define UCDS_IDX_DISCARD 12'h789
`define UCDS_IDX_VALID_HI 12'h78c
`define UCDS_IDX_VALID_LO 12'h78d
`define UCDS_IDX_SEC_BLK 12'h7a0
`define UCDS_IDX_DED_BLK 12'h7a1
`define UCDS_BIT_CMD_INIT 5
`define UCDS_BIT_CMD_TXOFF 4
`define UCDS_BIT_CMD_SOF 3
`define UCDS_BIT_CMD_BYTE 2
`define UCDS_BIT_CMD_CRC 0
`define UCDS_BIT_TX_SOF 4
`define UCDS_BIT_TX_WAIT 3
`define UCDS_BIT_RESP_SOF 2
`define UCDS_BIT_RESP_BYTE 1
`define UCDS_BIT_RESP_CRC 0
`define UCDS_CMD_MASK 8'h3d
`define UCDS_RESP_MASK 8'h1f
`define UCDS_RESET_BYTE 8'h00
`define UCDS_VALID_MAX 16'hffff
`define UCDS_DISCARD_MAX 8'hff
`endif

//--- rtl/ucds_debug_status.v
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "ucds_consts.vh"
module ucds_debug_status (
  // Clock and reset
  input wire core_clk,
  input wire arst_n,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // Command frame events from framing logic
  input wire cmd_start,
  input wire cmd_init_bad,
  input wire cmd_byte_bad,
  input wire cmd_crc_bad,
  input wire cmd_end,
  input wire cmd_wants_read,
  input wire tx_enabled,
  // Response frame events
  input wire resp_start,
  input wire resp_init_bad,
  input wire resp_byte_bad,
  input wire resp_crc_bad,
  input wire resp_end,
  // Transmit side events
  input wire tx_busy,
  input wire tx_waiting,
  input wire tx_frame_done,
  input wire tx_frame_bad,
  input wire link_clear,
  // OTP ECC events
  input wire otp_sec_event,
  input wire otp_ded_event,
  input wire [7:0] otp_block_addr,
  // Fault reset
  input wire fault_clear
);
  reg [7:0] cmd_flags;
  reg [7:0] resp_flags;
  reg [7:0] discard_cnt;
  reg [15:0] valid_cnt;
  reg [15:0] valid_snap;
  reg [7:0] sec_blk;
  reg [7:0] ded_blk;
  reg [7:0] next_cmd_flags;
  reg [7:0] next_resp_flags;
  wire c_act, c_init, c_byte, c_sof, c_crc, c_good;
  wire r_byte, r_sof, r_crc, r_good;
  wire [15:0] discard_sum;
  wire addr_phase;
  wire discard_read;
  wire [1:0] discard_inc;
  wire [1:0] valid_inc;

  ////////////////////////////////////////////////////////////////
  // Frame trackers, one per received direction
  ucds_frame_track u_cmd (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .frame_start(cmd_start),
    .link_clear(link_clear),
    .init_err(cmd_init_bad),
    .byte_err(cmd_byte_bad),
    .crc_err(cmd_crc_bad),
    .frame_end(cmd_end),
    .active(c_act),
    .ignoring(),
    .init_hit(c_init),
    .byte_hit(c_byte),
    .sof_hit(c_sof),
    .crc_hit(c_crc),
    .good_hit(c_good)
  );
  ucds_frame_track u_resp (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .frame_start(resp_start),
    .link_clear(link_clear),
    .init_err(resp_init_bad),
    .byte_err(resp_byte_bad),
    .crc_err(resp_crc_bad),
    .frame_end(resp_end),
    .active(),
    .ignoring(),
    .init_hit(),
    .byte_hit(r_byte),
    .sof_hit(r_sof),
    .crc_hit(r_crc),
    .good_hit(r_good)
  );

  ////////////////////////////////////////////////////////////////
  // Sticky error flags; a new event wins over fault_clear
  always @* begin
    next_cmd_flags = fault_clear ? `UCDS_RESET_BYTE : cmd_flags;
    if (c_init)
      next_cmd_flags[`UCDS_BIT_CMD_INIT] = 1'b1;
    if (cmd_end & c_act & cmd_wants_read & ~tx_enabled)
      next_cmd_flags[`UCDS_BIT_CMD_TXOFF] = 1'b1;
    if (c_sof)
      next_cmd_flags[`UCDS_BIT_CMD_SOF] = 1'b1;
    if (c_byte)
      next_cmd_flags[`UCDS_BIT_CMD_BYTE] = 1'b1;
    if (c_crc)
      next_cmd_flags[`UCDS_BIT_CMD_CRC] = 1'b1;
    next_cmd_flags = next_cmd_flags & `UCDS_CMD_MASK;
  end

  // Response init errors only start ignoring; no flag bit exists for them
  always @* begin
    next_resp_flags = fault_clear ? `UCDS_RESET_BYTE : resp_flags;
    if (link_clear & tx_busy)
      next_resp_flags[`UCDS_BIT_TX_SOF] = 1'b1;
    if (tx_waiting & (link_clear | cmd_start))
      next_resp_flags[`UCDS_BIT_TX_WAIT] = 1'b1;
    if (r_sof)
      next_resp_flags[`UCDS_BIT_RESP_SOF] = 1'b1;
    if (r_byte)
      next_resp_flags[`UCDS_BIT_RESP_BYTE] = 1'b1;
    if (r_crc)
      next_resp_flags[`UCDS_BIT_RESP_CRC] = 1'b1;
    next_resp_flags = next_resp_flags & `UCDS_RESP_MASK;
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_flags <= 8'h00;
      resp_flags <= 8'h00;
    end else begin
      cmd_flags <= next_cmd_flags;
      resp_flags <= next_resp_flags;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Frame counters
  assign discard_inc = {1'b0, c_crc} + {1'b0, r_crc} + {1'b0, tx_frame_done & tx_frame_bad};
  assign valid_inc = {1'b0, c_good} + {1'b0, r_good} + {1'b0, tx_frame_done & ~tx_frame_bad};

  function [15:0] sat_add;
    input [15:0] base;
    input [1:0] inc;
    input [15:0] lim;
    reg [16:0] sum;
    begin
      sum = {1'b0, base} + {15'h0000, inc};
      sat_add = (sum > {1'b0, lim}) ? lim : sum[15:0];
    end
  endfunction

  assign discard_sum = sat_add({8'h00, discard_cnt}, discard_inc, {8'h00, `UCDS_DISCARD_MAX});

  assign addr_phase = hsel & hready & htrans[1];
  // Snapshot happens at the read's address phase so the data phase returns it
  assign discard_read = addr_phase & ~hwrite & (haddr[13:2] == `UCDS_IDX_DISCARD);

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      discard_cnt <= 8'h00;
      valid_cnt <= 16'h0000;
      valid_snap <= 16'h0000;
    end else if (discard_read) begin
      // Events in this cycle start the fresh count so none are lost
      valid_snap <= valid_cnt;
      discard_cnt <= {6'h00, discard_inc};
      valid_cnt <= {14'h0000, valid_inc};
    end else begin
      discard_cnt <= discard_sum[7:0];
      valid_cnt <= sat_add(valid_cnt, valid_inc, `UCDS_VALID_MAX);
    end
  end

  ////////////////////////////////////////////////////////////////
  // OTP block capture
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sec_blk <= 8'h00;
      ded_blk <= 8'h00;
    end else begin
      if (otp_sec_event)
        sec_blk <= otp_block_addr;
      if (otp_ded_event)
        ded_blk <= otp_block_addr;
    end
  end

  ////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY, writes dropped
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Read data is registered at the address phase edge and held until the next read
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= 32'h00000000;
    end else if (addr_phase & ~hwrite) begin
      case (haddr[13:2])
        `UCDS_IDX_CMD_ERR: hrdata <= {24'h000000, next_cmd_flags};
        `UCDS_IDX_RESP_ERR: hrdata <= {24'h000000, next_resp_flags};
        `UCDS_IDX_DISCARD: hrdata <= {24'h000000, discard_cnt};
        `UCDS_IDX_VALID_HI: hrdata <= {24'h000000, valid_snap[15:8]};
        `UCDS_IDX_VALID_LO: hrdata <= {24'h000000, valid_snap[7:0]};
        `UCDS_IDX_SEC_BLK: hrdata <= {24'h000000, sec_blk};
        `UCDS_IDX_DED_BLK: hrdata <= {24'h000000, ded_blk};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end
endmodule

//--- rtl/ucds_frame_track.v
`timescale 1ns/1ps
`include "ucds_consts.vh"
module ucds_frame_track (
  // Clock and reset
  input wire core_clk,
  input wire arst_n,
  // Frame events for one direction, same clock
  input wire frame_start,
  input wire link_clear,
  input wire init_err,
  input wire byte_err,
  input wire crc_err,
  input wire frame_end,
  // Qualified results
  output wire active,
  output wire ignoring,
  output wire init_hit,
  output wire byte_hit,
  output wire sof_hit,
  output wire crc_hit,
  output wire good_hit
);
  reg in_frame;
  reg ign;
  assign active = in_frame & ~ign;
  assign ignoring = ign;
  assign init_hit = init_err & ~ign;
  assign byte_hit = byte_err & active & ~init_err;
  assign sof_hit = link_clear & in_frame & ~ign;
  assign crc_hit = frame_end & active & crc_err & ~byte_err;
  assign good_hit = frame_end & active & ~crc_err & ~byte_err;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      in_frame <= 1'b0;
      ign <= 1'b0;
    end else if (link_clear) begin
      in_frame <= 1'b0;
      ign <= 1'b0;
    end else begin
      if (init_hit | byte_hit)
        ign <= 1'b1;
      if (frame_start | init_err)
        in_frame <= 1'b1;
      else if (frame_end)
        in_frame <= 1'b0;
    end
  end
endmodule

//--- verification/test_ucds_debug_status.sv
`timescale 1ns/1ps
module test_ucds_debug_status;
  localparam logic [31:0] a_cmd = 32'h1e04, a_rsp = 32'h1e08, a_dsc = 32'h1e24, a_vhi = 32'h1e30;
  localparam logic [31:0] a_vlo = 32'h1e34, a_sec = 32'h1e80, a_ded = 32'h1e84;
  localparam logic [16:0] c_s = 17'h41, c_e = 17'h50, c_crc = 17'h58, c_nop = 17'h40, c_clr = 17'h10040;
  localparam logic [16:0] r_s = 17'hc0, r_crc = 17'hc40, r_bb = 17'h240, t_ok = 17'h4040;
  logic core_clk = 0;
  logic arst_n = 0;
  logic hsel = 0;
  logic [31:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic hwrite = 0;
  logic [31:0] hwdata = 0;
  logic fault_clear = 0;
  logic otp_sec_event = 0;
  logic otp_ded_event = 0;
  logic [7:0] otp_block_addr = 0;
  logic [31:0] r;
  logic [31:0] regs [7] = '{a_cmd, a_rsp, a_dsc, a_vhi, a_vlo, a_sec, a_ded};
  wire hreadyout;
  wire hresp;
  wire [31:0] hrdata;
  wire [16:0] lnk;
  int mismatches = 0;
  int comparisons = 0;
  int cyc = 0;
  always #20 core_clk = ~core_clk;
  ucds_host_link ucds_host_link_inst (.core_clk(core_clk), .lnk(lnk));
  ucds_debug_status ucds_debug_status_inst (.core_clk(core_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cmd_start(lnk[0]), .cmd_init_bad(lnk[1]),
    .cmd_byte_bad(lnk[2]), .cmd_crc_bad(lnk[3]), .cmd_end(lnk[4]), .cmd_wants_read(lnk[5]),
    .tx_enabled(lnk[6]), .resp_start(lnk[7]), .resp_init_bad(lnk[8]), .resp_byte_bad(lnk[9]),
    .resp_crc_bad(lnk[10]), .resp_end(lnk[11]), .tx_busy(lnk[12]), .tx_waiting(lnk[13]),
    .tx_frame_done(lnk[14]), .tx_frame_bad(lnk[15]), .link_clear(lnk[16]), .otp_sec_event(otp_sec_event),
    .otp_ded_event(otp_ded_event), .otp_block_addr(otp_block_addr), .fault_clear(fault_clear));
  ////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic compare(input [31:0] exp, input [31:0] got, input [31:0] where);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value register %h expected %h seen %h", where, exp, got);
    end
  endtask
  task automatic xfer(input logic w, input [31:0] a, output [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= 32'hffffffff;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  task automatic rd(input [31:0] a, input [7:0] e);
    logic [31:0] d;
    xfer(1'b0, a, d);
    compare({24'h0, e}, d, a);
  endtask
  task automatic otp(input logic s, input logic d, input [7:0] a);
    @(posedge core_clk);
    otp_sec_event <= s;
    otp_ded_event <= d;
    otp_block_addr <= a;
    @(posedge core_clk);
    otp_sec_event <= 1'b0;
    otp_ded_event <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 80000) begin
      mismatches++;
      report_and_stop;
    end
  end
  initial begin
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      xfer(1'b1, regs[i], r);
      rd(regs[i], 8'h00);
    end
    rd(32'h1e00, 8'h00);
    repeat (3) ucds_host_link_inst.frame(c_s, c_nop, c_e);
    ucds_host_link_inst.frame(c_s, c_nop, c_crc);
    ucds_host_link_inst.step(t_ok, 1);
    rd(a_cmd, 8'h01);
    rd(a_dsc, 8'h01);
    rd(a_vhi, 8'h00);
    rd(a_vlo, 8'h04);
    rd(a_dsc, 8'h00);
    rd(a_dsc, 8'h00);
    rd(a_vlo, 8'h00);
    @(posedge core_clk) fault_clear <= 1'b1;
    @(posedge core_clk) fault_clear <= 1'b0;
    rd(a_cmd, 8'h00);
    // None of the three ignored frames may count, and their CRC faults must not show
    ucds_host_link_inst.frame(c_s, 17'h42, c_crc);
    ucds_host_link_inst.frame(c_s, c_nop, c_crc);
    ucds_host_link_inst.step(c_clr, 1);
    ucds_host_link_inst.frame(c_s, 17'h44, c_crc);
    ucds_host_link_inst.step(c_clr, 1);
    ucds_host_link_inst.frame(c_s, c_nop, c_e);
    rd(a_cmd, 8'h24);
    rd(a_dsc, 8'h00);
    rd(a_vlo, 8'h01);
    ucds_host_link_inst.step(c_s, 1);
    ucds_host_link_inst.step(c_clr, 1);
    ucds_host_link_inst.frame(c_s, c_nop, 17'h30);
    rd(a_cmd, 8'h3c);
    xfer(1'b0, a_dsc, r);
    ucds_host_link_inst.frame(r_s, c_nop, r_crc);
    ucds_host_link_inst.frame(r_s, r_bb, r_crc);
    ucds_host_link_inst.step(c_clr, 1);
    ucds_host_link_inst.step(r_s, 1);
    ucds_host_link_inst.step(c_clr, 1);
    ucds_host_link_inst.step(17'h11040, 1);
    ucds_host_link_inst.frame(17'h2041, c_nop, c_e);
    rd(a_rsp, 8'h1f);
    rd(a_dsc, 8'h01);
    rd(a_vlo, 8'h01);
    ucds_host_link_inst.step(t_ok, 65540);
    rd(a_dsc, 8'h00);
    rd(a_vhi, 8'hff);
    rd(a_vlo, 8'hff);
    otp(1'b1, 1'b0, 8'h5a);
    otp(1'b0, 1'b1, 8'ha5);
    rd(a_ded, 8'ha5);
    rd(a_sec, 8'h5a);
    otp(1'b1, 1'b0, 8'h33);
    rd(a_sec, 8'h33);
    report_and_stop;
  end
endmodule

//--- verification/ucds_debug_status_chk.sv
`timescale 1ns/1ps
module ucds_debug_status_chk (
  // Clock and reset
  input wire core_clk,
  input wire arst_n,
  // Bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  // Events
  input wire cmd_end,
  input wire resp_end,
  input wire tx_frame_done,
  input wire otp_sec_event,
  input wire otp_ded_event,
  input wire [7:0] otp_block_addr
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire rd = hsel && hready && htrans[1] && !hwrite;
  wire quiet = !(cmd_end || resp_end || tx_frame_done);
  sequence disc_rd;
    rd && haddr[13:2] == 12'h789 && quiet;
  endsequence
  sequence sec_then_rd;
    otp_sec_event ##1 !otp_sec_event ##1 rd && haddr[13:2] == 12'h7a0;
  endsequence
  sequence ded_then_rd;
    otp_ded_event ##1 !otp_ded_event ##1 rd && haddr[13:2] == 12'h7a1;
  endsequence
  chk_zero_wait: assert property (hreadyout) else $error("wait state inserted");
  chk_resp_okay: assert property (!hresp) else $error("error response seen");
  chk_read_holds: assert property (!rd |=> $stable(hrdata)) else $error("read data moved");
  chk_upper_zero: assert property (hrdata[31:8] == 24'h0) else $error("upper read bits set");
  chk_reset_clean: assert property ($rose(arst_n) |-> hrdata == 32'h0) else $error("read data not zero");
  chk_unmapped_zero: assert property (rd && !(haddr[13:2] inside {12'h781, 12'h782, 12'h789, 12'h78c,
    12'h78d, 12'h7a0, 12'h7a1}) |=> hrdata == 32'h0) else $error("unmapped read not zero");
  chk_discard_reset: assert property (disc_rd ##1 quiet [*2] ##1 disc_rd |=> hrdata == 32'h0)
    else $error("discard count not reset by read");
  chk_sec_capture: assert property (sec_then_rd |=> hrdata[7:0] == $past(otp_block_addr, 3))
    else $error("corrected block address wrong");
  chk_ded_capture: assert property (ded_then_rd |=> hrdata[7:0] == $past(otp_block_addr, 3))
    else $error("uncorrectable block address wrong");
endmodule
bind ucds_debug_status ucds_debug_status_chk ucds_debug_status_chk_inst (.core_clk, .arst_n, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .cmd_end, .resp_end, .tx_frame_done, .otp_sec_event,
  .otp_ded_event, .otp_block_addr);

//--- verification/ucds_host_link.sv
`timescale 1ns/1ps
module ucds_host_link (
  // Clock
  input wire core_clk,
  // Framing strobes and levels, one bit each
  output logic [16:0] lnk
);
  // Between frames the transmitter stays enabled and every strobe is low
  localparam logic [16:0] idle_v = 17'h00040;
  initial lnk = idle_v;
  // A count above one stretches the event, as a slow host would
  task automatic step(input [16:0] v, input int n);
    repeat (n) @(posedge core_clk) lnk <= v;
    @(posedge core_clk) lnk <= idle_v;
  endtask
  task automatic frame(input [16:0] s, input [16:0] m, input [16:0] e);
    step(s, 1);
    step(m, 1);
    step(e, 1);
  endtask
endmodule
